// ==== shared/lowpower_cal_defines.vh ====
// Register offsets, field positions, reset values and interval constants for the calibration block.
`ifndef LOWPOWER_CAL_DEFINES_VH
`define LOWPOWER_CAL_DEFINES_VH

`define ADDR_W 12
`define DATA_W 8
`define OFF_LP_SCHEDULE 12'h06e
`define OFF_VEC_CTRL 12'h070
`define OFF_VEC_PORT 12'h071
`define OFF_GAIN_A 12'h07a
`define OFF_GAIN_B 12'h07b

`define RST_LP_SCHEDULE 8'h88
`define RST_VEC_CTRL 8'h00
`define RST_GAIN 8'h00

`define SLEEP_SEL_HI 7
`define SLEEP_SEL_LO 5
`define SETTLE_SEL_HI 4
`define SETTLE_SEL_LO 3
`define TRIG_MODE_BIT 1
`define LOWPOWER_CAL_ENABLE_BIT 0
`define VEC_EN_BIT 0

// Exponent k of each sleep and settle code.
`define SLEEP_K0 6'h03
`define SLEEP_K1 6'h0f
`define SLEEP_K2 6'h12
`define SLEEP_K3 6'h15
`define SLEEP_K4 6'h18
`define SLEEP_K5 6'h1b
`define SLEEP_K6 6'h1e
`define SLEEP_K7 6'h21
`define SETTLE_K0 6'h21
`define SETTLE_K1 6'h12
`define SETTLE_K2 6'h15
`define SETTLE_K3 6'h18

`define VEC_LEN 10'h2a1
`define VEC_LAST 10'h2a0
`define VEC_IDX_W 10

// Interval length is (2^k + 1) * 256 clocks; k is at most 33, so 42 bits suffice.
`define CNT_W 42
`define UNIT_SHIFT 8

`endif

// ==== hdl/cal_interval_timer.v ====
// Interval counter that measures (2^k + 1) * 256 clock periods.
`timescale 1ns/1ps
`default_nettype none
`include "lowpower_cal_defines.vh"

module cal_interval_timer (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Control
  input wire restart,
  input wire [5:0] exponent,
  // Status
  output reg expired
);

  reg [`CNT_W-1:0] count;
  wire [`CNT_W-1:0] limit;

  assign limit = ((({{(`CNT_W-1){1'b0}}, 1'b1}) << exponent) + {{(`CNT_W-1){1'b0}}, 1'b1})
                 << `UNIT_SHIFT;

  always @(posedge ref_clk) begin
    if (reset || restart) begin
      count <= {`CNT_W{1'b0}};
      expired <= 1'b0;
    end else if (!expired) begin
      // The flag is registered and read by the next edge, so it rises one count early.
      // This makes the interval last exactly limit clocks rather than one more.
      if (count == limit - {{(`CNT_W-2){1'b0}}, 2'h2}) begin
        expired <= 1'b1;
      end
      count <= count + {{(`CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // cal_interval_timer
`default_nettype wire

// ==== hdl/lowpower_cal_sched_and_cal_port.v ====
// Low-power calibration scheduler with sequential calibration-vector port.
`timescale 1ns/1ps
`default_nettype none
`include "lowpower_cal_defines.vh"

module lowpower_cal_sched_and_cal_port (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Register access
  input wire [`ADDR_W-1:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [`DATA_W-1:0] reg_wdata,
  output reg [`DATA_W-1:0] reg_rdata,
  // Calibration controls from elsewhere in the device
  input wire background_cal_enable,
  input wire cal_halted,
  input wire cal_trigger_pin,
  input wire software_cal_trigger,
  input wire trigger_source_sel,
  input wire [`DATA_W-1:0] gain_fuse_a,
  input wire [`DATA_W-1:0] gain_fuse_b,
  // Scheduler outputs
  output reg core_asleep,
  output reg cal_request,
  // Trim outputs
  output reg [`DATA_W-1:0] gain_adjust_chan_a,
  output reg [`DATA_W-1:0] gain_adjust_chan_b
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_SETTLE = 2'h2;
  localparam ST_CAL = 2'h3;

  reg [`DATA_W-1:0] lowpower_cal_schedule;
  reg [`DATA_W-1:0] cal_vector_port_ctrl;
  reg [`DATA_W-1:0] cal_vector [0:`VEC_LEN-1];
  reg [`VEC_IDX_W-1:0] vec_index;
  reg [1:0] state;
  reg [1:0] next_state;
  reg timer_restart;
  reg fuse_pending;
  wire timer_expired;
  wire [2:0] sleep_interval_sel;
  wire [1:0] settle_interval_sel;
  wire trigger_wake_mode;
  wire lowpower_cal_enable;
  wire lp_active;
  wire cal_trigger;
  wire vec_enabled;
  wire vec_access;
  reg [5:0] exponent;

  assign sleep_interval_sel = lowpower_cal_schedule[`SLEEP_SEL_HI:`SLEEP_SEL_LO];
  assign settle_interval_sel = lowpower_cal_schedule[`SETTLE_SEL_HI:`SETTLE_SEL_LO];
  assign trigger_wake_mode = lowpower_cal_schedule[`TRIG_MODE_BIT];
  assign lowpower_cal_enable = lowpower_cal_schedule[`LOWPOWER_CAL_ENABLE_BIT];
  assign lp_active = lowpower_cal_enable && background_cal_enable;
  assign cal_trigger = trigger_source_sel ? cal_trigger_pin : software_cal_trigger;
  assign vec_enabled = cal_vector_port_ctrl[`VEC_EN_BIT];
  // The host owns the halted check; the port does not guard corrupt accesses.
  assign vec_access = vec_enabled && (reg_addr == `OFF_VEC_PORT);

  function [5:0] sleep_exp;
    input [2:0] code;
    begin
      case (code)
        3'h0: sleep_exp = `SLEEP_K0;
        3'h1: sleep_exp = `SLEEP_K1;
        3'h2: sleep_exp = `SLEEP_K2;
        3'h3: sleep_exp = `SLEEP_K3;
        3'h4: sleep_exp = `SLEEP_K4;
        3'h5: sleep_exp = `SLEEP_K5;
        3'h6: sleep_exp = `SLEEP_K6;
        default: sleep_exp = `SLEEP_K7;
      endcase
    end
  endfunction

  function [5:0] settle_exp;
    input [1:0] code;
    begin
      case (code)
        2'h0: settle_exp = `SETTLE_K0;
        2'h1: settle_exp = `SETTLE_K1;
        2'h2: settle_exp = `SETTLE_K2;
        default: settle_exp = `SETTLE_K3;
      endcase
    end
  endfunction

  cal_interval_timer interval_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .restart(timer_restart),
    .exponent(exponent),
    .expired(timer_expired)
  );

  always @* begin
    next_state = state;
    timer_restart = 1'b0;
    exponent = (state == ST_SETTLE) ? settle_exp(settle_interval_sel)
                                    : sleep_exp(sleep_interval_sel);
    case (state)
      ST_IDLE: begin
        if (lp_active && cal_halted) begin
          next_state = ST_SLEEP;
          timer_restart = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (!lp_active) begin
          next_state = ST_IDLE;
        end else if (trigger_wake_mode ? !cal_trigger : timer_expired) begin
          next_state = ST_SETTLE;
          timer_restart = 1'b1;
        end
      end
      ST_SETTLE: begin
        if (!lp_active) begin
          next_state = ST_IDLE;
        end else if (timer_expired) begin
          next_state = ST_CAL;
        end
      end
      ST_CAL: begin
        // Calibration of the core runs until the engine halts at the requested phase or lp_active falls.
        if (cal_halted || !lp_active) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      core_asleep <= 1'b0;
      cal_request <= 1'b0;
    end else begin
      state <= next_state;
      core_asleep <= (next_state == ST_SLEEP);
      cal_request <= (next_state == ST_CAL);
    end
  end

  // Gain trims load from fuses one cycle after reset release, since a reset value may not be a port.
  always @(posedge ref_clk) begin
    if (reset) begin
      fuse_pending <= 1'b1;
      gain_adjust_chan_a <= `RST_GAIN;
      gain_adjust_chan_b <= `RST_GAIN;
    end else if (fuse_pending) begin
      fuse_pending <= 1'b0;
      gain_adjust_chan_a <= gain_fuse_a;
      gain_adjust_chan_b <= gain_fuse_b;
    end else if (reg_wr && reg_addr == `OFF_GAIN_A) begin
      gain_adjust_chan_a <= reg_wdata;
    end else if (reg_wr && reg_addr == `OFF_GAIN_B) begin
      gain_adjust_chan_b <= reg_wdata;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      lowpower_cal_schedule <= `RST_LP_SCHEDULE;
      cal_vector_port_ctrl <= `RST_VEC_CTRL;
    end else if (reg_wr) begin
      if (reg_addr == `OFF_LP_SCHEDULE) begin
        lowpower_cal_schedule <= reg_wdata;
      end
      if (reg_addr == `OFF_VEC_CTRL) begin
        cal_vector_port_ctrl <= reg_wdata;
      end
    end
  end

  // Any read or write of the enabled vector port advances the pointer, so a stream at a frozen address walks the vector.
  always @(posedge ref_clk) begin
    if (reset || !vec_enabled) begin
      vec_index <= {`VEC_IDX_W{1'b0}};
    end else if (vec_access && (reg_rd || reg_wr)) begin
      vec_index <= (vec_index == `VEC_LAST) ? {`VEC_IDX_W{1'b0}}
                                            : vec_index + {{(`VEC_IDX_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge ref_clk) begin
    if (vec_access && reg_wr) begin
      cal_vector[vec_index] <= reg_wdata;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= {`DATA_W{1'b0}};
    end else if (reg_rd) begin
      case (reg_addr)
        `OFF_LP_SCHEDULE: reg_rdata <= lowpower_cal_schedule;
        `OFF_VEC_CTRL: reg_rdata <= cal_vector_port_ctrl;
        `OFF_VEC_PORT: reg_rdata <= vec_enabled ? cal_vector[vec_index]
                                                : {`DATA_W{1'b0}};
        `OFF_GAIN_A: reg_rdata <= gain_adjust_chan_a;
        `OFF_GAIN_B: reg_rdata <= gain_adjust_chan_b;
        default: reg_rdata <= {`DATA_W{1'b0}};
      endcase
    end
  end

endmodule // lowpower_cal_sched_and_cal_port
`default_nettype wire

// ==== verif/lowpower_cal_sva.sv ====
// Port assertions for the calibration scheduler block.
`timescale 1ns/1ps
`default_nettype none
`include "lowpower_cal_defines.vh"
module lowpower_cal_sva (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Register access
  input wire [`ADDR_W-1:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [`DATA_W-1:0] reg_wdata,
  input wire [`DATA_W-1:0] reg_rdata,
  // Controls and outputs
  input wire background_cal_enable,
  input wire [`DATA_W-1:0] gain_fuse_a,
  input wire core_asleep,
  input wire cal_request,
  input wire [`DATA_W-1:0] gain_adjust_chan_a
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire mapped = reg_addr inside {`OFF_LP_SCHEDULE, `OFF_VEC_CTRL, `OFF_VEC_PORT, 12'h07a, 12'h07b};
  // The fuse load may land one edge late, so writes near release are left out.
  sequence s_wr_a;
    reg_wr && reg_addr == `OFF_GAIN_A && !$past(reset) && !$past(reset, 2);
  endsequence
  property p_reset_out;
    disable iff (1'b0) reset |=> reg_rdata == 8'h00 && !core_asleep && !cal_request;
  endproperty
  property p_unmapped; reg_rd && !mapped |=> reg_rdata == 8'h00; endproperty
  property p_rdata_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  property p_bg_drop; !background_cal_enable |-> ##[1:2] !core_asleep; endproperty
  property p_no_req_asleep; core_asleep |-> !cal_request; endproperty
  property p_gain_wr; s_wr_a |=> gain_adjust_chan_a == $past(reg_wdata); endproperty
  property p_gain_hold;
    !reg_wr && !$past(reset) && !$past(reset, 2) |=> $stable(gain_adjust_chan_a);
  endproperty
  property p_fuse; !reset && $past(reset) |-> ##[1:2] gain_adjust_chan_a == gain_fuse_a; endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset outputs");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  a_bg_drop: assert property (p_bg_drop) else $error("asleep w/o enable");
  a_no_req_asleep: assert property (p_no_req_asleep) else $error("early request");
  a_gain_wr: assert property (p_gain_wr) else $error("gain write lost");
  a_gain_hold: assert property (p_gain_hold) else $error("gain moved");
  a_fuse: assert property (p_fuse) else $error("fuse load");
endmodule // lowpower_cal_sva
`default_nettype wire

// ==== verif/cal_engine_model.sv ====
// Behavioural calibration engine that reports when it has halted.
`timescale 1ns/1ps
`default_nettype none
module cal_engine_model (
  // Clock
  input wire logic ref_clk,
  // Halt handshake
  input wire logic halt_req,
  output logic cal_halted
);
  logic [1:0] wait_cnt = 2'h0;
  initial cal_halted = 1'b0;
  // Stopping takes a few cycles but resuming is at once, so a host cannot lean on a stale flag.
  always @(posedge ref_clk) begin
    wait_cnt <= halt_req ? wait_cnt + 2'h1 : 2'h0;
    cal_halted <= halt_req && (cal_halted || wait_cnt == 2'h3);
  end
endmodule // cal_engine_model
`default_nettype wire

// ==== verif/lowpower_cal_sched_and_cal_port_bench.sv ====
// Self-checking bench for the calibration scheduler and vector port.
`timescale 1ns/1ps
`default_nettype none
`include "lowpower_cal_defines.vh"
module lowpower_cal_sched_and_cal_port_bench;
  localparam logic [7:0] FUSE_A = 8'h5c;
  localparam logic [7:0] FUSE_B = 8'ha3;
  logic ref_clk, reset, reg_wr, reg_rd, bg_en, trig_pin, soft_trig, trig_sel, halt_req;
  logic cal_halted, core_asleep, cal_request;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, gain_a, gain_b;
  int error_cnt, compares, n;
  cal_engine_model cal_engine_model_i (.ref_clk(ref_clk), .halt_req(halt_req),
    .cal_halted(cal_halted));
  lowpower_cal_sched_and_cal_port lowpower_cal_sched_and_cal_port_i (.ref_clk(ref_clk),
    .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .background_cal_enable(bg_en),
    .cal_halted(cal_halted), .cal_trigger_pin(trig_pin), .software_cal_trigger(soft_trig),
    .trigger_source_sel(trig_sel), .gain_fuse_a(FUSE_A), .gain_fuse_b(FUSE_B),
    .core_asleep(core_asleep), .cal_request(cal_request), .gain_adjust_chan_a(gain_a),
    .gain_adjust_chan_b(gain_b));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    @(negedge ref_clk);
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic wait_sleep(input logic lvl, input int lim);
    for (n = 0; n < lim && core_asleep !== lvl; n++)
      @(negedge ref_clk);
  endtask
  task automatic end_of_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {reset, halt_req, trig_pin} = 3'h7;
    {reg_wr, reg_rd, bg_en, soft_trig, trig_sel} = 5'h00;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    repeat (2) @(negedge ref_clk);
    rchk(`OFF_LP_SCHEDULE, `RST_LP_SCHEDULE);
    rchk(`OFF_VEC_CTRL, `RST_VEC_CTRL);
    rchk(`OFF_GAIN_A, FUSE_A);
    rchk(`OFF_GAIN_B, FUSE_B);
    rchk(12'h06f, 8'h00);
    rchk(`OFF_VEC_PORT, 8'h00);
    wr(`OFF_GAIN_A, 8'h3c);
    rchk(`OFF_GAIN_A, 8'h3c);
    wr(`OFF_GAIN_B, 8'hc3);
    rchk(`OFF_GAIN_B, 8'hc3);
    // Host streams at one address with the engine halted, and always moves the whole vector.
    wr(`OFF_VEC_CTRL, 8'h01);
    for (int i = 0; i < 673; i++)
      wr(`OFF_VEC_PORT, i[7:0] ^ 8'h5a);
    for (int i = 0; i < 673; i++)
      rchk(`OFF_VEC_PORT, i[7:0] ^ 8'h5a);
    wr(`OFF_VEC_CTRL, 8'h00);
    bg_en = 1'b1;
    repeat (20) @(negedge ref_clk);
    chk("core_asleep", 1'b0, core_asleep);
    wr(`OFF_LP_SCHEDULE, 8'h09);
    wait_sleep(1'b1, 8);
    chk("core_asleep", 1'b1, core_asleep);
    wait_sleep(1'b0, 3000);
    // Sleep code 0 lasts (2^3 + 1) * 256 clocks.
    chk("sleep_len", 32'h900, n);
    chk("cal_request", 1'b0, cal_request);
    wr(`OFF_LP_SCHEDULE, 8'h0b);
    for (int s = 1; s >= 0; s--) begin
      bg_en = 1'b0;
      trig_sel = s[0];
      trig_pin = s[0];
      soft_trig = !s[0];
      repeat (3) @(negedge ref_clk);
      bg_en = 1'b1;
      repeat (2400) @(negedge ref_clk);
      chk("core_asleep", 1'b1, core_asleep);
      trig_pin = 1'b0;
      soft_trig = 1'b0;
      wait_sleep(1'b0, 4);
      chk("core_asleep", 1'b0, core_asleep);
    end
    // Leave the schedule on a recommended sleep code once the short-code tests are done.
    wr(`OFF_LP_SCHEDULE, 8'h89);
    rchk(`OFF_LP_SCHEDULE, 8'h89);
    end_of_test;
  end
  initial begin
    #1000000;
    error_cnt++;
    end_of_test;
  end
endmodule // lowpower_cal_sched_and_cal_port_bench
bind lowpower_cal_sched_and_cal_port lowpower_cal_sva lowpower_cal_sva_i (.ref_clk(ref_clk),
  .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .background_cal_enable(background_cal_enable),
  .gain_fuse_a(gain_fuse_a), .core_asleep(core_asleep), .cal_request(cal_request),
  .gain_adjust_chan_a(gain_adjust_chan_a));
`default_nettype wire
